// File: dchp_pkg.sv
// Constants and timing shared by both ends of the controller link.
// Assumes one 200 MHz clock and strobes that are synchronous to it.
package dchp_pkg;
    // ************************************************
    // Widths and reset values
    // ************************************************
    localparam int          ADDR_W     = 6;
    localparam int          BYTE_W     = 8;
    localparam int          BUF_DEPTH  = 2;
    localparam int          CNT_W      = 8;
    localparam logic [7:0]  BYTE_IDLE  = 8'hFF;
    localparam logic [7:0]  BYTE_ZERO  = 8'h00;
    localparam logic [7:0]  CFG_RST    = 8'h00;
    // ************************************************
    // Drive-side register map and fields
    // ************************************************
    localparam logic [5:0]  REG_DMA_CFG   = 6'h00;
    localparam logic [5:0]  REG_USER_STAT = 6'h01;
    localparam logic [5:0]  REG_LINK_STAT = 6'h02;
    localparam int          CFG_DIR_BIT   = 0;
    localparam int          CFG_EN_BIT    = 1;
    // ************************************************
    // Timing
    // ************************************************
    localparam int CLK_NS     = 5;
    localparam int RD_STB_NS  = 500;
    localparam int WR_STB_NS  = 100;
    localparam int DAT_STB_NS = 50;
    localparam int GAP_NS     = 20;
    localparam int RD_STB_CYC  = (RD_STB_NS + CLK_NS - 1) / CLK_NS;
    localparam int WR_STB_CYC  = (WR_STB_NS + CLK_NS - 1) / CLK_NS;
    localparam int DAT_STB_CYC = (DAT_STB_NS + CLK_NS - 1) / CLK_NS;
    localparam int GAP_CYC     = (GAP_NS + CLK_NS - 1) / CLK_NS;
endpackage

// File: dchp_link_if.sv
// Wires between the host-side and drive-side controller ends.
// Resolves each shared line from the drive enables; undriven lines idle high.
`timescale 1ns/1ps
`default_nettype none
interface dchp_link_if;
    import dchp_pkg::*;
    logic [ADDR_W-1:0] ctl_stat_addr;
    logic              ctl_stat_read_strobe_n;
    logic              ctl_stat_write_strobe_n;
    logic [BYTE_W-1:0] cs_host_out;
    logic              cs_host_oe;
    logic [BYTE_W-1:0] cs_dev_out;
    logic              cs_dev_oe;
    logic [BYTE_W-1:0] ctl_stat_bus;
    logic [BYTE_W-1:0] rw_host_out;
    logic              rw_host_oe;
    logic [BYTE_W-1:0] rw_dev_out;
    logic              rw_dev_oe;
    logic [BYTE_W-1:0] rw_data_bus;
    logic              ob_req_out_n;
    logic              ob_req_oe;
    logic              ib_req_out_n;
    logic              ib_req_oe;
    logic              outbound_dma_req_n;
    logic              inbound_dma_req_n;
    logic              outbound_data_strobe_n;
    logic              inbound_data_strobe_n;

    assign ctl_stat_bus = cs_host_oe ? cs_host_out : (cs_dev_oe ? cs_dev_out : BYTE_IDLE);
    assign rw_data_bus  = rw_host_oe ? rw_host_out : (rw_dev_oe ? rw_dev_out : BYTE_IDLE);
    assign outbound_dma_req_n = ob_req_oe ? ob_req_out_n : 1'b1;
    assign inbound_dma_req_n  = ib_req_oe ? ib_req_out_n : 1'b1;

    modport host (
        output ctl_stat_addr, ctl_stat_read_strobe_n, ctl_stat_write_strobe_n,
        output cs_host_out, cs_host_oe, rw_host_out, rw_host_oe,
        output outbound_data_strobe_n, inbound_data_strobe_n,
        input  ctl_stat_bus, rw_data_bus, outbound_dma_req_n, inbound_dma_req_n
    );
    modport device (
        input  ctl_stat_addr, ctl_stat_read_strobe_n, ctl_stat_write_strobe_n,
        input  outbound_data_strobe_n, inbound_data_strobe_n,
        input  ctl_stat_bus, rw_data_bus,
        output cs_dev_out, cs_dev_oe, rw_dev_out, rw_dev_oe,
        output ob_req_out_n, ob_req_oe, ib_req_out_n, ib_req_oe
    );
endinterface
`default_nettype wire

// File: dchp_device.sv
// Drive-side end: control/status registers, request lines, two-entry buffer.
// Assumes host strobes are synchronous to clk_sys and held at least two cycles.
`timescale 1ns/1ps
`default_nettype none
module dchp_device
    import dchp_pkg::*;
#(
    parameter int DEPTH = BUF_DEPTH
) (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst,
    // Link
    dchp_link_if.device            link,
    // Selection and status
    input  wire logic              dev_selected,
    input  wire logic [BYTE_W-1:0] status_in,
    output var  logic [BYTE_W-1:0] dma_cfg,
    // Control byte report
    output var  logic              ctl_wr_pulse,
    output var  logic [ADDR_W-1:0] ctl_wr_addr,
    output var  logic [BYTE_W-1:0] ctl_wr_data,
    // Inbound stream from user
    input  wire logic              in_valid,
    input  wire logic [BYTE_W-1:0] in_data,
    output var  logic              in_ready,
    // Outbound stream to user
    output var  logic              out_valid,
    output var  logic [BYTE_W-1:0] out_data,
    input  wire logic              out_ready
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] CNT0 = '0;
    localparam logic [PW-1:0] PTR0 = '0;

    // ************************************************
    // State
    // ************************************************
    logic              wr_prev_q, ob_prev_q, ib_prev_q;
    logic [BYTE_W-1:0] cfg_q, cfg_d;
    logic [ADDR_W-1:0] hold_a_q, hold_a_d;
    logic [BYTE_W-1:0] hold_c_q, hold_c_d;
    logic [BYTE_W-1:0] hold_b_q, hold_b_d;
    logic              pulse_q, pulse_d;
    logic [ADDR_W-1:0] wa_q, wa_d;
    logic [BYTE_W-1:0] wd_q, wd_d;
    logic [BYTE_W-1:0] cs_out_q, cs_out_d;
    logic              cs_oe_q, cs_oe_d;
    logic [BYTE_W-1:0] rw_out_q, rw_out_d;
    logic              rw_oe_q, rw_oe_d;
    logic              obr_q, obr_d, obe_q, obe_d;
    logic              ibr_q, ibr_d, ibe_q, ibe_d;
    logic [BYTE_W-1:0] mem_q [DEPTH];
    logic [BYTE_W-1:0] mem_d [DEPTH];
    logic [PW-1:0]     wp_q, wp_d, rp_q, rp_d;
    logic [CW-1:0]     cnt_q, cnt_d;
    logic              ov_q, ov_d, ir_q, ir_d;
    logic [BYTE_W-1:0] od_q, od_d;
    logic              dir_in, en, wr_rise, ob_rise, ib_rise, push, pop;
    logic [BYTE_W-1:0] push_data;

    // ************************************************
    // Next state
    // ************************************************
    always_comb begin
        cfg_d    = cfg_q;
        hold_a_d = hold_a_q;
        hold_c_d = hold_c_q;
        hold_b_d = hold_b_q;
        pulse_d  = 1'b0;
        wa_d     = wa_q;
        wd_d     = wd_q;
        mem_d    = mem_q;
        wp_d     = wp_q;
        rp_d     = rp_q;
        cnt_d    = cnt_q;
        dir_in   = cfg_q[CFG_DIR_BIT];
        en       = cfg_q[CFG_EN_BIT] & dev_selected;
        // Latch every low cycle while selected so the byte seen last before the rise is kept
        if (dev_selected && !link.ctl_stat_write_strobe_n) begin
            hold_a_d = link.ctl_stat_addr;
            hold_c_d = link.ctl_stat_bus;
        end
        wr_rise = dev_selected & ~wr_prev_q & link.ctl_stat_write_strobe_n;
        if (wr_rise) begin
            pulse_d = 1'b1;
            wa_d    = hold_a_q;
            wd_d    = hold_c_q;
            if (hold_a_q == REG_DMA_CFG) begin
                cfg_d = hold_c_q;
            end
        end
        // Status read: drive while strobe is low and selected, registered so one cycle behind the strobe
        cs_oe_d  = dev_selected & ~link.ctl_stat_read_strobe_n;
        cs_out_d = BYTE_IDLE;
        if (cs_oe_d) begin
            if (link.ctl_stat_addr == REG_DMA_CFG) begin
                cs_out_d = cfg_q;
            end else if (link.ctl_stat_addr == REG_USER_STAT) begin
                cs_out_d = status_in;
            end else if (link.ctl_stat_addr == REG_LINK_STAT) begin
                cs_out_d = {{(BYTE_W - CW){1'b0}}, cnt_q};
            end else begin
                cs_out_d = BYTE_ZERO;
            end
        end
        // Data path through the buffer
        if (en && !dir_in && !link.outbound_data_strobe_n) begin
            hold_b_d = link.rw_data_bus;
        end
        ob_rise   = en & ~dir_in & ~ob_prev_q & link.outbound_data_strobe_n;
        ib_rise   = en & dir_in & ~ib_prev_q & link.inbound_data_strobe_n;
        push_data = dir_in ? in_data : hold_b_q;
        push      = (dir_in ? (in_valid & ir_q) : ob_rise) & (cnt_q != FULL);
        pop       = (dir_in ? ib_rise : (ov_q & out_ready)) & (cnt_q != CNT0);
        if (push) begin
            mem_d[wp_q] = push_data;
            wp_d        = (wp_q == LAST) ? PTR0 : wp_q + 1'b1;
        end
        if (pop) begin
            rp_d = (rp_q == LAST) ? PTR0 : rp_q + 1'b1;
        end
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
        // A new direction must not inherit bytes meant for the other way
        if (wr_rise && hold_a_q == REG_DMA_CFG) begin
            wp_d  = PTR0;
            rp_d  = PTR0;
            cnt_d = CNT0;
        end
        ov_d     = ~cfg_d[CFG_DIR_BIT] & (cnt_d != CNT0);
        ir_d     = cfg_d[CFG_DIR_BIT] & (cnt_d != FULL);
        od_d     = mem_d[rp_d];
        rw_oe_d  = en & dir_in & ~link.inbound_data_strobe_n & ~ib_rise;
        rw_out_d = rw_oe_d ? mem_d[rp_d] : BYTE_IDLE;
        // Only the selected line is enabled; the other floats for sharing
        obe_d = cfg_d[CFG_EN_BIT] & dev_selected & ~cfg_d[CFG_DIR_BIT];
        ibe_d = cfg_d[CFG_EN_BIT] & dev_selected & cfg_d[CFG_DIR_BIT];
        obr_d = ~(obe_d & (cnt_d != FULL));
        ibr_d = ~(ibe_d & (cnt_d != CNT0));
    end

    // ************************************************
    // Registers
    // ************************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wr_prev_q <= 1'b1;
            ob_prev_q <= 1'b1;
            ib_prev_q <= 1'b1;
            cfg_q     <= CFG_RST;
            hold_a_q  <= '0;
            hold_c_q  <= BYTE_ZERO;
            hold_b_q  <= BYTE_ZERO;
            pulse_q   <= 1'b0;
            wa_q      <= '0;
            wd_q      <= BYTE_ZERO;
            cs_out_q  <= BYTE_IDLE;
            cs_oe_q   <= 1'b0;
            rw_out_q  <= BYTE_IDLE;
            rw_oe_q   <= 1'b0;
            obr_q     <= 1'b1;
            obe_q     <= 1'b0;
            ibr_q     <= 1'b1;
            ibe_q     <= 1'b0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= BYTE_ZERO;
            end
            wp_q      <= PTR0;
            rp_q      <= PTR0;
            cnt_q     <= CNT0;
            ov_q      <= 1'b0;
            ir_q      <= 1'b0;
            od_q      <= BYTE_ZERO;
        end else begin
            wr_prev_q <= link.ctl_stat_write_strobe_n;
            ob_prev_q <= link.outbound_data_strobe_n;
            ib_prev_q <= link.inbound_data_strobe_n;
            cfg_q     <= cfg_d;
            hold_a_q  <= hold_a_d;
            hold_c_q  <= hold_c_d;
            hold_b_q  <= hold_b_d;
            pulse_q   <= pulse_d;
            wa_q      <= wa_d;
            wd_q      <= wd_d;
            cs_out_q  <= cs_out_d;
            cs_oe_q   <= cs_oe_d;
            rw_out_q  <= rw_out_d;
            rw_oe_q   <= rw_oe_d;
            obr_q     <= obr_d;
            obe_q     <= obe_d;
            ibr_q     <= ibr_d;
            ibe_q     <= ibe_d;
            mem_q     <= mem_d;
            wp_q      <= wp_d;
            rp_q      <= rp_d;
            cnt_q     <= cnt_d;
            ov_q      <= ov_d;
            ir_q      <= ir_d;
            od_q      <= od_d;
        end
    end

    // ************************************************
    // Outputs
    // ************************************************
    assign link.cs_dev_out   = cs_out_q;
    assign link.cs_dev_oe    = cs_oe_q;
    assign link.rw_dev_out   = rw_out_q;
    assign link.rw_dev_oe    = rw_oe_q;
    assign link.ob_req_out_n = obr_q;
    assign link.ob_req_oe    = obe_q;
    assign link.ib_req_out_n = ibr_q;
    assign link.ib_req_oe    = ibe_q;
    assign dma_cfg           = cfg_q;
    assign ctl_wr_pulse      = pulse_q;
    assign ctl_wr_addr       = wa_q;
    assign ctl_wr_data       = wd_q;
    assign in_ready          = ir_q;
    assign out_valid         = ov_q;
    assign out_data          = od_q;
endmodule
`default_nettype wire

// File: dchp_host.sv
// Host-side end: runs control/status cycles and paced data strobes.
// Assumes the drive-side end answers with one cycle of register delay.
`timescale 1ns/1ps
`default_nettype none
module dchp_host
    import dchp_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst,
    // Link
    dchp_link_if.host              link,
    // Control/status commands
    input  wire logic              cmd_valid,
    input  wire logic              cmd_write,
    input  wire logic [ADDR_W-1:0] cmd_addr,
    input  wire logic [BYTE_W-1:0] cmd_wdata,
    output var  logic              cmd_ready,
    output var  logic              rsp_valid,
    output var  logic [BYTE_W-1:0] rsp_data,
    // Outbound bytes
    input  wire logic              tx_valid,
    input  wire logic [BYTE_W-1:0] tx_data,
    output var  logic              tx_ready,
    // Inbound bytes
    output var  logic              rx_valid,
    output var  logic [BYTE_W-1:0] rx_data,
    input  wire logic              rx_ready
);
    typedef enum logic [2:0] {H_IDLE, H_CSRD, H_CSWR, H_DOUT, H_DIN, H_GAP} dchp_hstate_t;

    // ************************************************
    // State
    // ************************************************
    dchp_hstate_t      st_q, st_d;
    logic [CNT_W-1:0]  cnt_q, cnt_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic              rd_n_q, rd_n_d, wr_n_q, wr_n_d;
    logic [BYTE_W-1:0] cso_q, cso_d;
    logic              cse_q, cse_d;
    logic [BYTE_W-1:0] rwo_q, rwo_d;
    logic              rwe_q, rwe_d;
    logic              obs_q, obs_d, ibs_q, ibs_d;
    logic              crdy_q, crdy_d, trdy_q, trdy_d;
    logic              rspv_q, rspv_d, rxv_q, rxv_d;
    logic [BYTE_W-1:0] rspd_q, rspd_d, rxd_q, rxd_d;

    // ************************************************
    // Next state
    // ************************************************
    always_comb begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        addr_d = addr_q;
        rd_n_d = rd_n_q;
        wr_n_d = wr_n_q;
        cso_d  = cso_q;
        cse_d  = cse_q;
        rwo_d  = rwo_q;
        rwe_d  = rwe_q;
        obs_d  = obs_q;
        ibs_d  = ibs_q;
        crdy_d = 1'b0;
        trdy_d = 1'b0;
        rspv_d = 1'b0;
        rspd_d = rspd_q;
        rxv_d  = rxv_q & ~rx_ready;
        rxd_d  = rxd_q;
        case (st_q)
            H_IDLE: begin
                if (cmd_valid) begin
                    crdy_d = 1'b1;
                    addr_d = cmd_addr;
                    if (cmd_write) begin
                        cso_d  = cmd_wdata;
                        cse_d  = 1'b1;
                        wr_n_d = 1'b0;
                        cnt_d  = CNT_W'(WR_STB_CYC - 1);
                        st_d   = H_CSWR;
                    end else begin
                        rd_n_d = 1'b0;
                        cnt_d  = CNT_W'(RD_STB_CYC - 1);
                        st_d   = H_CSRD;
                    end
                end else if (tx_valid && !link.outbound_dma_req_n) begin
                    trdy_d = 1'b1;
                    rwo_d  = tx_data;
                    rwe_d  = 1'b1;
                    obs_d  = 1'b0;
                    cnt_d  = CNT_W'(DAT_STB_CYC - 1);
                    st_d   = H_DOUT;
                end else if (!rxv_q && !link.inbound_dma_req_n) begin
                    ibs_d = 1'b0;
                    cnt_d = CNT_W'(DAT_STB_CYC - 1);
                    st_d  = H_DIN;
                end
            end
            H_CSRD, H_CSWR, H_DOUT, H_DIN: begin
                if (cnt_q == '0) begin
                    if (st_q == H_CSRD) begin
                        rspv_d = 1'b1;
                        rspd_d = link.ctl_stat_bus;
                    end
                    if (st_q == H_DIN) begin
                        rxv_d = 1'b1;
                        rxd_d = link.rw_data_bus;
                    end
                    rd_n_d = 1'b1;
                    wr_n_d = 1'b1;
                    obs_d  = 1'b1;
                    ibs_d  = 1'b1;
                    cse_d  = 1'b0;
                    rwe_d  = 1'b0;
                    // Gap lets the far end release the bus and refresh its request
                    cnt_d  = CNT_W'(GAP_CYC - 1);
                    st_d   = H_GAP;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            H_GAP: begin
                if (cnt_q == '0) begin
                    st_d = H_IDLE;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            default: begin
                st_d = H_IDLE;
            end
        endcase
    end

    // ************************************************
    // Registers
    // ************************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_q   <= H_IDLE;
            cnt_q  <= '0;
            addr_q <= '0;
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
            cso_q  <= BYTE_ZERO;
            cse_q  <= 1'b0;
            rwo_q  <= BYTE_ZERO;
            rwe_q  <= 1'b0;
            obs_q  <= 1'b1;
            ibs_q  <= 1'b1;
            crdy_q <= 1'b0;
            trdy_q <= 1'b0;
            rspv_q <= 1'b0;
            rspd_q <= BYTE_ZERO;
            rxv_q  <= 1'b0;
            rxd_q  <= BYTE_ZERO;
        end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            addr_q <= addr_d;
            rd_n_q <= rd_n_d;
            wr_n_q <= wr_n_d;
            cso_q  <= cso_d;
            cse_q  <= cse_d;
            rwo_q  <= rwo_d;
            rwe_q  <= rwe_d;
            obs_q  <= obs_d;
            ibs_q  <= ibs_d;
            crdy_q <= crdy_d;
            trdy_q <= trdy_d;
            rspv_q <= rspv_d;
            rspd_q <= rspd_d;
            rxv_q  <= rxv_d;
            rxd_q  <= rxd_d;
        end
    end

    // ************************************************
    // Outputs
    // ************************************************
    assign link.ctl_stat_addr           = addr_q;
    assign link.ctl_stat_read_strobe_n  = rd_n_q;
    assign link.ctl_stat_write_strobe_n = wr_n_q;
    assign link.cs_host_out             = cso_q;
    assign link.cs_host_oe              = cse_q;
    assign link.rw_host_out             = rwo_q;
    assign link.rw_host_oe              = rwe_q;
    assign link.outbound_data_strobe_n  = obs_q;
    assign link.inbound_data_strobe_n   = ibs_q;
    assign cmd_ready                    = crdy_q;
    assign tx_ready                     = trdy_q;
    assign rsp_valid                    = rspv_q;
    assign rsp_data                     = rspd_q;
    assign rx_valid                     = rxv_q;
    assign rx_data                      = rxd_q;
endmodule
`default_nettype wire

// File: dchp_link_if_note_placeholder_none.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: dchp_link_asserts.sv
// Checker for the controller link between the two ends.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module dchp_link_asserts
    import dchp_pkg::*;
(
    // Clock and reset
    input wire logic              clk_sys,
    input wire logic              rst,
    // Link signals
    input wire logic [ADDR_W-1:0] ctl_stat_addr,
    input wire logic              ctl_stat_read_strobe_n,
    input wire logic              ctl_stat_write_strobe_n,
    input wire logic              cs_host_oe,
    input wire logic              cs_dev_oe,
    input wire logic              rw_host_oe,
    input wire logic              rw_dev_oe,
    input wire logic              ob_req_oe,
    input wire logic              ib_req_oe,
    input wire logic              outbound_data_strobe_n,
    input wire logic              inbound_data_strobe_n
);
    logic rd_n, wr_n, ob_n, ib_n;
    assign rd_n = ctl_stat_read_strobe_n;
    assign wr_n = ctl_stat_write_strobe_n;
    assign ob_n = outbound_data_strobe_n;
    assign ib_n = inbound_data_strobe_n;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    property p_rd_len; $fell(rd_n) |-> ##99 !rd_n ##1 rd_n; endproperty
    a_rd_len: assert property (p_rd_len) else $error("read strobe length");
    property p_cs_dev; cs_dev_oe |-> !rd_n || $past(!rd_n); endproperty
    a_cs_dev: assert property (p_cs_dev) else $error("status bus driven off read");
    property p_cs_one; !(cs_host_oe && cs_dev_oe); endproperty
    a_cs_one: assert property (p_cs_one) else $error("status bus contention");
    property p_wr_len; $fell(wr_n) |-> ##19 !wr_n ##1 wr_n; endproperty
    a_wr_len: assert property (p_wr_len) else $error("write strobe length");
    property p_wr_drv; !wr_n |-> cs_host_oe && !cs_dev_oe; endproperty
    a_wr_drv: assert property (p_wr_drv) else $error("write byte not driven");
    property p_ds_len; $fell(ob_n) |-> ##9 !ob_n ##1 ob_n; endproperty
    a_ds_len: assert property (p_ds_len) else $error("data strobe length");
    property p_req_one; !(ob_req_oe && ib_req_oe); endproperty
    a_req_one: assert property (p_req_one) else $error("both request lines");
    property p_rw_one; !(rw_host_oe && rw_dev_oe); endproperty
    a_rw_one: assert property (p_rw_one) else $error("data bus contention");
    property p_rw_dev; rw_dev_oe |-> !ib_n || $past(!ib_n); endproperty
    a_rw_dev: assert property (p_rw_dev) else $error("data driven off strobe");
    property p_addr; !rd_n && $past(!rd_n) |-> $stable(ctl_stat_addr); endproperty
    a_addr: assert property (p_addr) else $error("address moved in read");
    c_rd: cover property ($fell(rd_n));
    c_wr: cover property ($fell(wr_n));
    c_in: cover property ($rose(rw_dev_oe));
endmodule
`default_nettype wire

// File: dchp_tb.sv
// Self-checking bench: host end and drive end joined by the link.
// Assumes a 200 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import dchp_pkg::*;
;
    logic clk_sys, rst, cmd_valid, cmd_write, cmd_ready, rsp_valid;
    logic tx_valid, tx_ready, rx_valid, rx_ready, dev_selected, ctl_wr_pulse;
    logic in_valid, in_ready, out_valid, out_ready, drain;
    logic [5:0] cmd_addr, ctl_wr_addr;
    logic [7:0] cmd_wdata, rsp_data, tx_data, rx_data, status_in, dma_cfg;
    logic [7:0] ctl_wr_data, in_data, out_data, q, cfg_m;
    logic [7:0] ob_q[$], ib_q[$];
    logic [5:0] u_addr[4] = '{6'h00, 6'h01, 6'h3F, 6'h2A};
    int seed = 32'h19F126EC;
    int fail_count, total_checks, cycles, n, wr_pulses;
    dchp_link_if link();
    dchp_host u_dchp_host(.clk_sys(clk_sys), .rst(rst), .link(link),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready));
    dchp_device u_dchp_device(.clk_sys(clk_sys), .rst(rst), .link(link),
        .dev_selected(dev_selected), .status_in(status_in), .dma_cfg(dma_cfg),
        .ctl_wr_pulse(ctl_wr_pulse), .ctl_wr_addr(ctl_wr_addr), .ctl_wr_data(ctl_wr_data),
        .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready),
        .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready));
    dchp_link_asserts u_dchp_link_asserts(.clk_sys(clk_sys), .rst(rst),
        .ctl_stat_addr(link.ctl_stat_addr), .cs_host_oe(link.cs_host_oe),
        .ctl_stat_read_strobe_n(link.ctl_stat_read_strobe_n), .cs_dev_oe(link.cs_dev_oe),
        .ctl_stat_write_strobe_n(link.ctl_stat_write_strobe_n), .ib_req_oe(link.ib_req_oe),
        .rw_host_oe(link.rw_host_oe), .rw_dev_oe(link.rw_dev_oe), .ob_req_oe(link.ob_req_oe),
        .outbound_data_strobe_n(link.outbound_data_strobe_n),
        .inbound_data_strobe_n(link.inbound_data_strobe_n));
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic end_of_test;
        if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Expected read data; buffer count is checked by hand
    function automatic logic [7:0] exp_rd(input logic [5:0] a);
        if (a == REG_DMA_CFG) return cfg_m;
        if (a == REG_USER_STAT) return status_in;
        return 8'h00;
    endfunction
    // Waits for the reply to a read, or 30 cycles after a write, then keeps the gap before the next command
    task automatic cs_op(input logic wr, input logic [5:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        {cmd_valid, cmd_write, cmd_addr, cmd_wdata} = {1'b1, wr, a, d};
        n = 0;
        do @(posedge clk_sys); while (cmd_ready !== 1'b1 && ++n < 400);
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        n = 0;
        if (wr) repeat (30) @(negedge clk_sys);
        else begin
            do @(posedge clk_sys); while (rsp_valid !== 1'b1 && ++n < 200);
            q = rsp_data;
            repeat (6) @(negedge clk_sys);
        end
    endtask
    task automatic send(input logic ib, input logic [7:0] d);
        @(negedge clk_sys);
        if (ib) {in_valid, in_data} = {1'b1, d};
        else {tx_valid, tx_data} = {1'b1, d};
        if (ib) ib_q.push_back(d);
        else ob_q.push_back(d);
        n = 0;
        do @(posedge clk_sys); while ((ib ? in_ready : tx_ready) !== 1'b1 && ++n < 400);
        @(negedge clk_sys);
        {in_valid, tx_valid} = 2'b00;
    endtask
    always @(negedge clk_sys) begin
        out_ready <= drain & 1'($random(seed));
        rx_ready <= 1'($random(seed));
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (!rst && ctl_wr_pulse) wr_pulses++;
        if (cycles == 20000) begin
            fail_count++;
            end_of_test();
        end
        if (!rst && out_valid && out_ready) chk(out_data, ob_q.pop_front());
        if (!rst && rx_valid && rx_ready) chk(rx_data, ib_q.pop_front());
    end
    initial begin
        {cmd_valid, cmd_write, cmd_addr, cmd_wdata, tx_valid, tx_data} = '0;
        {in_valid, in_data, drain, cfg_m} = '0;
        {rst, dev_selected, status_in} = {1'b1, 1'b1, 8'(unsigned'($random(seed)))};
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        chk(dma_cfg, 8'h00);
        cs_op(1'b1, REG_DMA_CFG, 8'h02);
        cfg_m = 8'h02;
        chk({2'h0, ctl_wr_addr}, 8'h00);
        chk(ctl_wr_data, 8'h02);
        chk(dma_cfg, 8'h02);
        foreach (u_addr[i]) begin
            cs_op(1'b0, u_addr[i], 8'h00);
            chk(q, exp_rd(u_addr[i]));
        end
        dev_selected = 1'b0;
        cs_op(1'b1, REG_DMA_CFG, 8'h03);
        cs_op(1'b0, REG_USER_STAT, 8'h00);
        chk(q, 8'hFF);
        dev_selected = 1'b1;
        cs_op(1'b0, REG_DMA_CFG, 8'h00);
        chk(q, exp_rd(REG_DMA_CFG));
        repeat (2) send(1'b0, 8'($random(seed)));
        cs_op(1'b0, REG_LINK_STAT, 8'h00);
        chk(q, 8'h02);
        drain = 1'b1;
        repeat (8) send(1'b0, 8'($random(seed)));
        send(1'b0, 8'hFF);
        repeat (100) @(posedge clk_sys);
        cs_op(1'b1, REG_DMA_CFG, 8'h03);
        repeat (10) send(1'b1, 8'($random(seed)));
        send(1'b1, 8'h00);
        repeat (100) @(posedge clk_sys);
        chk(8'(ob_q.size() + ib_q.size()), 8'h00);
        chk(8'(wr_pulses), 8'h02);
        end_of_test();
    end
endmodule
`default_nettype wire
